// *** hdl/supply_reset_low_power_ctrl.sv ***
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "lpc_params.svh"
module supply_reset_low_power_ctrl
  import lpc_pkg::*;
#(
  parameter int EVT_LINES = `LPC_EVT_LINES,
  parameter int WAKE_PINS = `LPC_WAKE_PINS,
  parameter int OSC_CYC   = `LPC_OSC_CYC,
  parameter int POR_CYC   = `LPC_POR_CYC
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Supplies and option bit
  input  wire supply_s               supply,
  input  wire logic                  analog_check_off,
  // CPU requests and events
  input  wire logic                  cpu_sleep_req,
  input  wire logic                  periph_event,
  // Stop wake sources
  input  wire logic [EVT_LINES-1:0]  external_event_lines,
  input  wire logic                  rtc_event,
  input  wire logic                  first_two_wire_port_wake,
  input  wire logic                  first_serial_port_wake,
  // Standby wake sources
  input  wire logic                  reset_pin_n,
  input  wire logic                  independent_watchdog_reset,
  input  wire logic [WAKE_PINS-1:0]  wake_pins,
  // Power control and interrupt
  output pwr_ctl_s                   pwr,
  output logic                       irq
);
  localparam logic [`LPC_TMR_W-1:0] OSC_LOAD = `LPC_TMR_W'(OSC_CYC);
  localparam logic [`LPC_TMR_W-1:0] POR_LOAD = `LPC_TMR_W'(POR_CYC);

  pm_state_e                  state;
  pm_state_e                  next_state;
  pwr_ctl_s                   next_pwr;
  logic [`LPC_CTRL_W-1:0]     ctrl;
  logic [`LPC_IRQ_W-1:0]      irq_status;
  logic [`LPC_IRQ_W-1:0]      irq_mask;
  logic [`LPC_IRQ_W-1:0]      irq_set;
  logic [WAKE_PINS-1:0]       wake_pins_q;
  logic                       supply_hold;
  logic                       por_done;
  logic                       monitor_event;
  logic                       monitor_level;
  logic                       timer_load;
  logic [`LPC_TMR_W-1:0]      timer_count;
  logic                       timer_done;
  logic                       stop_wake;
  logic                       standby_wake;
  logic                       wake_pin_rise;
  logic                       setup;
  logic                       access;
  logic                       wr_en;
  logic [`LPC_ADDR_W-1:0]     addr;
  logic [31:0]                next_rdata;
  logic                       next_err;
  logic [31:0]                status_word;

  supply_supervisor u_supervisor (
    .pclk             (pclk),
    .presetn          (presetn),
    .supply           (supply),
    .analog_check_off (analog_check_off),
    .monitor_en       (ctrl[`LPC_CTRL_MON_EN]),
    .on_fall          (ctrl[`LPC_CTRL_FALL]),
    .on_rise          (ctrl[`LPC_CTRL_RISE]),
    .supply_hold      (supply_hold),
    .por_done         (por_done),
    .monitor_event    (monitor_event),
    .monitor_level    (monitor_level)
  );

  settle_timer #(
    .W (`LPC_TMR_W)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (timer_load),
    .count   (timer_count),
    .done    (timer_done)
  );

  // Wake sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_pins_q <= '0;
    end else begin
      wake_pins_q <= wake_pins;
    end
  end

  assign wake_pin_rise = |(wake_pins & ~wake_pins_q);

  // Monitor output counts as an event line only when it fires
  assign stop_wake = (|external_event_lines) || monitor_event || rtc_event ||
                     first_two_wire_port_wake || first_serial_port_wake;

  assign standby_wake = !reset_pin_n || independent_watchdog_reset ||
                        wake_pin_rise || rtc_event;

  // Mode sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_POR: begin
        if (timer_done && !supply_hold) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cpu_sleep_req) begin
          unique case (lp_mode_e'(ctrl[`LPC_CTRL_MODE]))
            MODE_SLEEP:   next_state = ST_SLEEP;
            MODE_STOP:    next_state = ST_STOP;
            MODE_STANDBY: next_state = ST_STANDBY;
            MODE_RSVD:    next_state = ST_SLEEP;
          endcase
        end
      end
      ST_SLEEP: begin
        if (periph_event || stop_wake) begin
          next_state = ST_RUN;
        end
      end
      ST_STOP: begin
        if (stop_wake) begin
          next_state = ST_OSC;
        end
      end
      ST_OSC: begin
        if (timer_done) begin
          next_state = ST_RUN;
        end
      end
      ST_STANDBY: begin
        if (standby_wake) begin
          next_state = ST_POR;
        end
      end
      default: next_state = ST_POR;
    endcase
    if (supply_hold) begin
      next_state = ST_POR;
    end
  end

  // Every fresh entry into a timed state restarts the count
  assign timer_load  = (next_state != state || supply_hold) &&
                       (next_state == ST_POR || next_state == ST_OSC);
  assign timer_count = (next_state == ST_OSC) ? OSC_LOAD : POR_LOAD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_POR;
    end else begin
      state <= next_state;
    end
  end

  // Power controls follow the next state so they change with it
  always_comb begin
    next_pwr = '{cpu_clk_en: 1'b1, core_clk_en: 1'b1, pll_en: 1'b1,
                 internal_rc_osc_en: 1'b1, external_hf_osc_en: 1'b1,
                 regulator_on: 1'b1, regulator_lp: 1'b0, core_reset_n: 1'b1};
    unique case (next_state)
      ST_POR: begin
        next_pwr.cpu_clk_en   = 1'b0;
        next_pwr.core_clk_en  = 1'b0;
        next_pwr.pll_en       = 1'b0;
        next_pwr.core_reset_n = 1'b0;
      end
      ST_RUN: begin
        next_pwr.cpu_clk_en = 1'b1;
      end
      ST_SLEEP: begin
        next_pwr.cpu_clk_en = 1'b0;
      end
      ST_STOP: begin
        next_pwr.cpu_clk_en         = 1'b0;
        next_pwr.core_clk_en        = 1'b0;
        next_pwr.pll_en             = 1'b0;
        next_pwr.internal_rc_osc_en = 1'b0;
        next_pwr.external_hf_osc_en = 1'b0;
        next_pwr.regulator_lp       = ctrl[`LPC_CTRL_REG_LP];
      end
      ST_OSC: begin
        next_pwr.cpu_clk_en  = 1'b0;
        next_pwr.core_clk_en = 1'b0;
        next_pwr.pll_en      = 1'b0;
      end
      ST_STANDBY: begin
        next_pwr.cpu_clk_en         = 1'b0;
        next_pwr.core_clk_en        = 1'b0;
        next_pwr.pll_en             = 1'b0;
        next_pwr.internal_rc_osc_en = 1'b0;
        next_pwr.external_hf_osc_en = 1'b0;
        next_pwr.regulator_on       = 1'b0;
        next_pwr.core_reset_n       = 1'b0;
      end
      default: next_pwr.core_reset_n = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr <= '{cpu_clk_en: 1'b0, core_clk_en: 1'b0, pll_en: 1'b0,
               internal_rc_osc_en: 1'b1, external_hf_osc_en: 1'b1,
               regulator_on: 1'b1, regulator_lp: 1'b0, core_reset_n: 1'b0};
    end else begin
      pwr <= next_pwr;
    end
  end

  // APB slave, one wait state so all outputs come from flops
  assign setup  = psel && !penable;
  assign access = psel && penable && !pready;
  assign wr_en  = psel && penable && pready && pwrite && !pslverr;
  assign addr   = paddr[`LPC_ADDR_W-1:0];

  always_comb begin
    status_word                   = '0;
    status_word[`LPC_ST_STATE]    = state;
    status_word[`LPC_ST_MON_LVL]  = monitor_level;
    status_word[`LPC_ST_HOLD]     = supply_hold;
    status_word[`LPC_ST_POR_DONE] = por_done;
  end

  always_comb begin
    next_rdata = '0;
    next_err   = 1'b0;
    unique case (addr)
      `LPC_OFS_CTRL:    next_rdata = 32'(ctrl);
      `LPC_OFS_STATUS:  next_rdata = status_word;
      `LPC_OFS_IRQ_ST:  next_rdata = 32'(irq_status);
      `LPC_OFS_IRQ_MSK: next_rdata = 32'(irq_mask);
      default:          next_err   = 1'b1;
    endcase
    if (paddr[31:`LPC_ADDR_W] != '0) begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= access;
      pslverr <= access && next_err;
      if (access && !pwrite && !next_err) begin
        prdata <= next_rdata;
      end else if (setup) begin
        prdata <= '0;
      end
    end
  end

  // Control is core state, so Standby wipes it like a reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `LPC_CTRL_RST;
    end else if (state == ST_STANDBY) begin
      ctrl <= `LPC_CTRL_RST;
    end else if (wr_en && addr == `LPC_OFS_CTRL && pstrb[0]) begin
      ctrl <= pwdata[`LPC_CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `LPC_IRQ_RST;
    end else if (state == ST_STANDBY) begin
      irq_mask <= `LPC_IRQ_RST;
    end else if (wr_en && addr == `LPC_OFS_IRQ_MSK && pstrb[0]) begin
      irq_mask <= pwdata[`LPC_IRQ_W-1:0];
    end
  end

  // Events
  always_comb begin
    irq_set                 = '0;
    irq_set[`LPC_IRQ_MON]   = monitor_event;
    irq_set[`LPC_IRQ_STOP]  = state == ST_OSC && timer_done;
    irq_set[`LPC_IRQ_STBY]  = state == ST_STANDBY && standby_wake;
  end

  // Status lives with the standby logic; set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `LPC_IRQ_RST;
    end else if (wr_en && addr == `LPC_OFS_IRQ_ST && pstrb[0]) begin
      irq_status <= (irq_status & ~pwdata[`LPC_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule

// *** hdl/lpc_params.svh ***
`ifndef LPC_PARAMS_SVH
`define LPC_PARAMS_SVH
// Overview of operation
// - Supply supervisors always active; chip held in reset while supply below threshold.
// - Startup release of reset watches only the main I/O and regulator supply.
// - Falling-supply check covers main and analog supply; option bit disables analog check.
// - Software-enabled monitor interrupts on supply falling below, rising above, or both.
// - Sleep stops only the CPU clock; any peripheral interrupt or event wakes it.
// - Stop halts core clocks, PLL and both oscillators, keeping SRAM and registers.
// - In Stop the regulator stays normal or low-power as software selects.
// - Stop ends on any external event line, monitor, RTC, two-wire or serial port.
// - Standby switches off regulator, core domain, PLL and both oscillators.
// - After Standby core state is lost; only RTC and standby logic keep state.
// - Standby ends on reset pin low, watchdog reset, wake pin rise or RTC event.

// Register byte offsets
`define LPC_ADDR_W      12
`define LPC_OFS_CTRL    12'h000
`define LPC_OFS_STATUS  12'h004
`define LPC_OFS_IRQ_ST  12'h008
`define LPC_OFS_IRQ_MSK 12'h00C

// Control register fields
`define LPC_CTRL_MON_EN 0
`define LPC_CTRL_FALL   1
`define LPC_CTRL_RISE   2
`define LPC_CTRL_REG_LP 3
`define LPC_CTRL_MODE   5:4
`define LPC_CTRL_W      6
`define LPC_CTRL_RST    6'h00

// Interrupt status and mask fields
`define LPC_IRQ_MON     0
`define LPC_IRQ_STOP    1
`define LPC_IRQ_STBY    2
`define LPC_IRQ_W       3
`define LPC_IRQ_RST     3'h0

// Status register fields
`define LPC_ST_STATE    2:0
`define LPC_ST_MON_LVL  3
`define LPC_ST_HOLD     4
`define LPC_ST_POR_DONE 5

// Timing
`define LPC_CLK_PS      5000
`define LPC_OSC_NS      2000
`define LPC_POR_NS      1000
`define LPC_OSC_CYC     ((`LPC_OSC_NS * 1000 + `LPC_CLK_PS - 1) / `LPC_CLK_PS)
`define LPC_POR_CYC     ((`LPC_POR_NS * 1000 + `LPC_CLK_PS - 1) / `LPC_CLK_PS)
`define LPC_TMR_W       12
`define LPC_EVT_LINES   16
`define LPC_WAKE_PINS   2
`endif

// *** hdl/lpc_pkg.sv ***
package lpc_pkg;
  typedef enum logic [2:0] {
    ST_POR     = 3'h0,
    ST_RUN     = 3'h1,
    ST_SLEEP   = 3'h2,
    ST_STOP    = 3'h3,
    ST_OSC     = 3'h4,
    ST_STANDBY = 3'h5
  } pm_state_e;

  typedef enum logic [1:0] {
    MODE_SLEEP   = 2'h0,
    MODE_STOP    = 2'h1,
    MODE_STANDBY = 2'h2,
    MODE_RSVD    = 2'h3
  } lp_mode_e;

  typedef struct packed {
    logic cpu_clk_en;
    logic core_clk_en;
    logic pll_en;
    logic internal_rc_osc_en;
    logic external_hf_osc_en;
    logic regulator_on;
    logic regulator_lp;
    logic core_reset_n;
  } pwr_ctl_s;

  typedef struct packed {
    logic main_supply_ok;
    logic analog_supply_ok;
    logic main_below_monitor_threshold;
  } supply_s;
endpackage

// *** hdl/supply_supervisor.sv ***
`timescale 1ns/1ps
`include "lpc_params.svh"
module supply_supervisor
  import lpc_pkg::*;
(
  // Clock and reset
  input  wire logic    pclk,
  input  wire logic    presetn,
  // Supply comparators
  input  wire supply_s supply,
  input  wire logic    analog_check_off,
  // Monitor control
  input  wire logic    monitor_en,
  input  wire logic    on_fall,
  input  wire logic    on_rise,
  // Results
  output logic         supply_hold,
  output logic         por_done,
  output logic         monitor_event,
  output logic         monitor_level
);
  logic next_hold;

  // Until the first release only the main supply counts
  always_comb begin
    if (!por_done) begin
      next_hold = !supply.main_supply_ok;
    end else begin
      next_hold = !supply.main_supply_ok ||
                  (!supply.analog_supply_ok && !analog_check_off);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_hold <= 1'b1;
      por_done    <= 1'b0;
    end else begin
      supply_hold <= next_hold;
      // Sticky, so a later analog drop cannot fall back to the startup rule
      por_done    <= por_done || !next_hold;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_level <= 1'b0;
      monitor_event <= 1'b0;
    end else begin
      monitor_level <= monitor_en && supply.main_below_monitor_threshold;
      monitor_event <= monitor_en && (
        (on_fall && supply.main_below_monitor_threshold && !monitor_level) ||
        (on_rise && !supply.main_below_monitor_threshold && monitor_level));
    end
  end
endmodule

// *** hdl/settle_timer.sv ***
`timescale 1ns/1ps
`include "lpc_params.svh"
module settle_timer #(
  parameter int W = `LPC_TMR_W
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] remain;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain <= '0;
    end else if (load) begin
      remain <= count;
    end else if (remain != '0) begin
      remain <= remain - W'(1);
    end
  end

  // Done only once the full count ran out, never on the load cycle
  assign done = !load && (remain == '0);
endmodule

// *** dv/supply_reset_low_power_ctrl_properties.sv ***
`timescale 1ns/1ps
module lpc_checker
  import lpc_pkg::*;
#(
  parameter int EVT_LINES = 16,
  parameter int OSC_CYC   = 4,
  parameter int POR_CYC   = 4
) (
  // Clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // Supplies and wake sources
  input wire supply_s              supply,
  input wire logic                 periph_event,
  input wire logic [EVT_LINES-1:0] external_event_lines,
  input wire logic                 rtc_event,
  input wire logic                 first_two_wire_port_wake,
  input wire logic                 first_serial_port_wake,
  input wire logic                 reset_pin_n,
  // Power control
  input wire pwr_ctl_s             pwr
);
  // One cycle of slack for the registered state hop
  localparam int MIN_CYC = ((OSC_CYC < POR_CYC) ? OSC_CYC : POR_CYC) - 1;
  logic        in_stop;
  logic        stop_wake;
  logic [15:0] dark_cnt;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign in_stop   = pwr.regulator_on && !pwr.internal_rc_osc_en;
  assign stop_wake = (|external_event_lines) || rtc_event || first_two_wire_port_wake || first_serial_port_wake;

  // Oscillators up, core clocks still held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dark_cnt <= 16'h0000;
    end else if (pwr.core_clk_en || !pwr.internal_rc_osc_en) begin
      dark_cnt <= 16'h0000;
    end else begin
      dark_cnt <= dark_cnt + 16'h0001;
    end
  end

  sequence por_hold_s;
    !pwr.core_reset_n [*3];
  endsequence
  sequence oscs_off_s;
    !pwr.pll_en && !pwr.internal_rc_osc_en && !pwr.external_hf_osc_en && !pwr.core_clk_en;
  endsequence

  supply_hold_a: assert property (!supply.main_supply_ok |-> ##[1:3] !pwr.core_reset_n)
    else $error("core reset not held with main supply low");
  sleep_only_a: assert property ($fell(pwr.cpu_clk_en) && pwr.core_clk_en |-> pwr.pll_en && pwr.regulator_on)
    else $error("sleep stopped more than the cpu clock");
  sleep_wake_a: assert property (!pwr.cpu_clk_en && pwr.core_clk_en && periph_event |-> ##[1:2] pwr.cpu_clk_en)
    else $error("peripheral event did not wake sleep");
  stop_clocks_a: assert property (in_stop |-> !pwr.core_clk_en && !pwr.cpu_clk_en && !pwr.pll_en)
    else $error("clock left running in stop");
  stop_lp_a: assert property ($rose(pwr.regulator_lp) |-> in_stop)
    else $error("low power regulator outside stop");
  stop_wake_a: assert property (in_stop && stop_wake |-> ##[1:2] pwr.internal_rc_osc_en)
    else $error("stop not left on wake source");
  osc_settle_a: assert property ($rose(pwr.core_clk_en) |-> dark_cnt >= MIN_CYC)
    else $error("core clock restarted before oscillator settled");
  standby_off_a: assert property (!pwr.regulator_on |-> oscs_off_s)
    else $error("oscillator or pll alive in standby");
  standby_wake_a: assert property (!pwr.regulator_on && !reset_pin_n |-> ##[1:3] pwr.regulator_on)
    else $error("reset pin did not end standby");
  standby_por_a: assert property ($rose(pwr.regulator_on) |-> por_hold_s)
    else $error("standby exit skipped reset sequence");
endmodule

bind supply_reset_low_power_ctrl lpc_checker #(
  .EVT_LINES(EVT_LINES),
  .OSC_CYC  (OSC_CYC),
  .POR_CYC  (POR_CYC)
) u_lpc_checker (
  .pclk(pclk), .presetn(presetn), .supply(supply), .periph_event(periph_event),
  .external_event_lines(external_event_lines), .rtc_event(rtc_event),
  .first_two_wire_port_wake(first_two_wire_port_wake), .first_serial_port_wake(first_serial_port_wake),
  .reset_pin_n(reset_pin_n), .pwr(pwr)
);

// *** dv/cpu_wake_model.sv ***
`timescale 1ns/1ps
module cpu_wake_model
  import lpc_pkg::*;
(
  // Clock
  input  wire logic   pclk,
  // Supplies
  output supply_s     supply,
  // CPU and wake sources
  output logic        cpu_sleep_req,
  output logic        periph_event,
  output logic [15:0] external_event_lines,
  output logic        rtc_event,
  output logic        two_wire_wake,
  output logic        serial_wake,
  output logic        reset_pin_n,
  output logic        watchdog_reset,
  output logic [1:0]  wake_pins
);
  initial begin
    supply = 3'b000;
    {cpu_sleep_req, periph_event, rtc_event, two_wire_wake, serial_wake, watchdog_reset} = 6'h00;
    external_event_lines = 16'h0000;
    reset_pin_n = 1'b1;
    wake_pins = 2'b00;
  end

  task automatic set_supply(input supply_s s);
    @(posedge pclk);
    supply <= s;
  endtask

  task automatic sleep_req();
    @(posedge pclk);
    cpu_sleep_req <= 1'b1;
    @(posedge pclk);
    cpu_sleep_req <= 1'b0;
  endtask

  // Every source waits dly cycles; dly also picks the line or pin; levels hold two cycles only
  task automatic fire(input int kind, input int dly);
    repeat (dly) @(posedge pclk);
    case (kind)
      0: external_event_lines <= 16'h0001 << (dly % 16);
      1: rtc_event <= 1'b1;
      2: two_wire_wake <= 1'b1;
      3: serial_wake <= 1'b1;
      4: periph_event <= 1'b1;
      5: reset_pin_n <= 1'b0;
      6: watchdog_reset <= 1'b1;
      default: wake_pins <= (dly % 4 == 2) ? 2'b10 : 2'b01;
    endcase
    repeat (2) @(posedge pclk);
    {periph_event, rtc_event, two_wire_wake, serial_wake, watchdog_reset} <= 5'h00;
    external_event_lines <= 16'h0000;
    reset_pin_n <= 1'b1;
    wake_pins <= 2'b00;
  endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`include "lpc_params.svh"
module tb_top
  import lpc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, analog_check_off;
  logic [31:0] paddr, pwdata, prdata, rd;
  supply_s     supply;
  pwr_ctl_s    pwr;
  logic        sleep_req, periph_event, rtc_event, two_wire_wake, serial_wake, reset_pin_n, watchdog_reset;
  logic [15:0] ext_lines;
  logic [1:0]  wake_pins;
  logic [3:0]  strb;
  int          n_mismatch, comparisons, cyc;
  int          sb_src [5] = '{5, 6, 7, 1, 7};

  // Short settle counts keep the run small
  supply_reset_low_power_ctrl #(.OSC_CYC(8), .POR_CYC(8)) u_supply_reset_low_power_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply(supply),
    .analog_check_off(analog_check_off), .cpu_sleep_req(sleep_req), .periph_event(periph_event),
    .external_event_lines(ext_lines), .rtc_event(rtc_event), .first_two_wire_port_wake(two_wire_wake),
    .first_serial_port_wake(serial_wake), .reset_pin_n(reset_pin_n), .independent_watchdog_reset(watchdog_reset),
    .wake_pins(wake_pins), .pwr(pwr), .irq(irq)
  );
  cpu_wake_model u_cpu_wake_model (
    .pclk(pclk), .supply(supply), .cpu_sleep_req(sleep_req), .periph_event(periph_event),
    .external_event_lines(ext_lines), .rtc_event(rtc_event), .two_wire_wake(two_wire_wake),
    .serial_wake(serial_wake), .reset_pin_n(reset_pin_n), .watchdog_reset(watchdog_reset), .wake_pins(wake_pins)
  );

  always #2.5 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr_en;
    paddr  <= {20'h00000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic wait_run();
    int n;
    n = 0;
    while (pwr !== 8'hFD && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    check(32'(pwr), 32'hFD);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, analog_check_off} = 4'h0;
    strb = 4'hF;
    paddr = 32'h0;
    pwdata = 32'h0;
    n_mismatch = 0;
    comparisons = 0;
    cyc = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    u_cpu_wake_model.set_supply(3'b010);
    repeat (8) @(posedge pclk);
    check(32'(pwr.core_reset_n), 32'h0);
    u_cpu_wake_model.set_supply(3'b110);
    wait_run();
    rd_chk(`LPC_OFS_CTRL, 32'h0);
    rd_chk(`LPC_OFS_IRQ_ST, 32'h0);
    rd_chk(`LPC_OFS_IRQ_MSK, 32'h0);
    rd_chk(`LPC_OFS_STATUS, 32'h21);
    rd_chk(12'h010, 32'h0);
    check(32'(err), 32'h1);
    // Byte lane 0 off, so the write must not land
    strb <= 4'hE;
    wr(`LPC_OFS_CTRL, 32'h3F);
    strb <= 4'hF;
    rd_chk(`LPC_OFS_CTRL, 32'h0);
    // Odd passes use reserved mode 3, which behaves as Sleep; every event line wakes once
    for (int j = 0; j < 17; j++) begin
      wr(`LPC_OFS_CTRL, j[0] ? 32'h30 : 32'h0);
      u_cpu_wake_model.sleep_req();
      repeat (2) @(posedge pclk);
      check(32'(pwr), 32'h7D);
      u_cpu_wake_model.fire((j < 16) ? 0 : 4, j);
      check(32'(pwr), 32'hFD);
    end
    wr(`LPC_OFS_IRQ_MSK, 32'h6);
    for (int k = 0; k < 4; k++) begin
      wr(`LPC_OFS_CTRL, 32'h10 | (32'(k & 1) << 3));
      u_cpu_wake_model.sleep_req();
      repeat (2) @(posedge pclk);
      check(32'(pwr), 32'h05 | (32'(k & 1) << 1));
      u_cpu_wake_model.fire(k, 3 * k);
      @(posedge pclk);
      check(32'({pwr.internal_rc_osc_en, pwr.core_clk_en}), 32'h2);
      wait_run();
      rd_chk(`LPC_OFS_IRQ_ST, 32'h2);
      check(32'(irq), 32'h1);
      wr(`LPC_OFS_IRQ_ST, 32'h2);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h0);
    end
    for (int i = 0; i < 5; i++) begin
      wr(`LPC_OFS_IRQ_MSK, 32'h6);
      wr(`LPC_OFS_CTRL, 32'h20);
      u_cpu_wake_model.sleep_req();
      repeat (2) @(posedge pclk);
      check(32'(pwr.regulator_on), 32'h0);
      u_cpu_wake_model.fire(sb_src[i], i);
      check(32'(pwr.core_reset_n), 32'h0);
      wait_run();
      rd_chk(`LPC_OFS_CTRL, 32'h0);
      rd_chk(`LPC_OFS_IRQ_ST, 32'h4);
      check(32'(irq), 32'h0);
      wr(`LPC_OFS_IRQ_ST, 32'h4);
    end
    wr(`LPC_OFS_CTRL, 32'h3);
    u_cpu_wake_model.set_supply(3'b111);
    repeat (4) @(posedge pclk);
    rd_chk(`LPC_OFS_STATUS, 32'h29);
    rd_chk(`LPC_OFS_IRQ_ST, 32'h1);
    wr(`LPC_OFS_IRQ_ST, 32'h1);
    u_cpu_wake_model.set_supply(3'b110);
    repeat (4) @(posedge pclk);
    rd_chk(`LPC_OFS_IRQ_ST, 32'h0);
    wr(`LPC_OFS_CTRL, 32'h5);
    u_cpu_wake_model.set_supply(3'b111);
    repeat (4) @(posedge pclk);
    rd_chk(`LPC_OFS_IRQ_ST, 32'h0);
    u_cpu_wake_model.set_supply(3'b110);
    repeat (4) @(posedge pclk);
    rd_chk(`LPC_OFS_IRQ_ST, 32'h1);
    // Both directions enabled
    wr(`LPC_OFS_CTRL, 32'h7);
    wr(`LPC_OFS_IRQ_ST, 32'h1);
    u_cpu_wake_model.set_supply(3'b111);
    repeat (4) @(posedge pclk);
    rd_chk(`LPC_OFS_IRQ_ST, 32'h1);
    wr(`LPC_OFS_IRQ_ST, 32'h1);
    u_cpu_wake_model.set_supply(3'b110);
    repeat (4) @(posedge pclk);
    rd_chk(`LPC_OFS_IRQ_ST, 32'h1);
    // Analog rail drops on purpose to probe the falling-supply check
    for (int k = 0; k < 2; k++) begin
      analog_check_off <= k[0];
      u_cpu_wake_model.set_supply(3'b100);
      repeat (4) @(posedge pclk);
      check(32'(pwr.core_reset_n), 32'(k));
      rd_chk(`LPC_OFS_STATUS, k ? 32'h21 : 32'h30);
      u_cpu_wake_model.set_supply(3'b110);
      wait_run();
    end
    // Reset again mid-run: outputs fall back at once, control is wiped
    presetn <= 1'b0;
    @(posedge pclk);
    check(32'(pwr), 32'h1C);
    presetn <= 1'b1;
    wait_run();
    rd_chk(`LPC_OFS_CTRL, 32'h0);
    check(32'(irq), 32'h0);
    final_report();
  end
endmodule
